//--- logic/mtsp_serial_port.sv
`timescale 1ns/1ps
`include "mtsp_regs.svh"

// Operation
// - all pins high is idle, no transfer
// - serial operation only while select low
// - select low: sync high reads, low writes
// - all reads pass 32-bit transmission latches
// - data moves trailing edge, sampled leading edge
// - long sync pulse, select idle, latches results
// - sync pulse at shift start clears counter
// - 32 clocks per record, up to eight
// - select release aborts shifting at once
// - bytes LSB first, top nibble is parity
// - fixed record order, reorder swaps halves
// - bits MSB first unless order bit set
// - command byte: data, address, execute bit
// - execute clock strobes latch, no measurement clock
// - write while select and sync low, driver off
// - remote reset gives internal reset, no restarts
// - remote reset keeps mode bits
// - weak pull-ups make undriven pins idle high
// - reorder request not stored, resent each read
// - config bits cleared by power-on only
module mtsp_serial_port (
  // measurement clock and power-on reset
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_I,
  // link pins
  input  wire logic                     SERIAL_CLOCK_SIGNAL_I,
  input  wire logic                     PORT_SELECT_N_I,
  input  wire logic                     SYNC_DIRECTION_I,
  input  wire logic                     SERIAL_DATA_SIGNAL_I,
  output logic                          SERIAL_DATA_SIGNAL_O,
  output logic                          SERIAL_DATA_SIGNAL_OE_O,
  // measurement results
  input  wire mtsp_pkg::mtsp_records_t  RECORD_I,
  // written bits and internal reset
  output mtsp_pkg::mtsp_cfg_t           CONFIG_O,
  output mtsp_pkg::mtsp_mode_t          MODE_O,
  output logic                          REMOTE_RESET_REQUEST_O
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // top nibble of the last byte is overwritten with column parity
  function automatic mtsp_pkg::mtsp_word_t mtsp_with_parity(input mtsp_pkg::mtsp_word_t w);
    mtsp_pkg::mtsp_word_t r;
    logic [3:0]           p;
    r = w;
    p = 4'h0;
    for (int i = 0; i < 7; i++) begin
      p = p ^ w[i*4 +: 4];
    end
    r[`MTSP_PARITY_LSB +: 4] = p;
    return r;
  endfunction

  // bit 31 of the result leaves first; least significant byte first
  function automatic mtsp_pkg::mtsp_word_t mtsp_serialize(input mtsp_pkg::mtsp_word_t w,
                                                          input logic                 lsb_first);
    mtsp_pkg::mtsp_word_t p;
    mtsp_pkg::mtsp_word_t r;
    logic [2:0]           bit_sel;
    p = mtsp_with_parity(w);
    r = '0;
    for (int b = 0; b < `MTSP_WORD_BITS; b++) begin
      bit_sel = lsb_first ? 3'(b) : 3'(7 - (b % 8));
      r[31 - b] = p[(b / 8) * 8 + int'(bit_sel)];
    end
    return r;
  endfunction

  // record slot for a position in the stream, halves swapped on request
  function automatic logic [2:0] mtsp_slot(input logic [2:0] pos,
                                           input logic       swap);
    return {pos[2] ^ swap, pos[1:0]};
  endfunction

  // select idle and sync active, with the serial clock at a given level
  function automatic logic mtsp_idle_sync(input logic sel_n,
                                          input logic syn,
                                          input logic clk,
                                          input logic clk_level);
    return sel_n & ~syn & (clk == clk_level);
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  mtsp_pkg::mtsp_mclk_t  mc;
  mtsp_pkg::mtsp_mclk_t  next_mc;
  mtsp_pkg::mtsp_rd_t    rd;
  mtsp_pkg::mtsp_rd_t    next_rd;
  mtsp_pkg::mtsp_cfg_t   cfg_w;
  mtsp_pkg::mtsp_mode_t  mode_w;
  logic                  swap_w;
  logic                  rd_mode;
  logic                  rd_rst;
  logic                  lsb_first;
  logic                  lat_cond;
  logic                  rrr_cond;
  logic [7:0]            cnt_inc;
  mtsp_pkg::mtsp_word_t  first_word;
  mtsp_pkg::mtsp_word_t  next_word;

  // ----------------------------------------------------------------------
  // write path: serial clock only, config and mode reset by power-on only
  // ----------------------------------------------------------------------
  mtsp_write u_write (
    .sclk_i    (SERIAL_CLOCK_SIGNAL_I),
    .por_i     (RST_I),
    .sel_n_i   (PORT_SELECT_N_I),
    .syn_i     (SYNC_DIRECTION_I),
    .sdi_i     (SERIAL_DATA_SIGNAL_I),
    .rd_last_i (rd.last),
    .cfg_o     (cfg_w),
    .mode_o    (mode_w),
    .swap_o    (swap_w)
  );

  assign lsb_first = cfg_w[`MTSP_ORDER_ADDR];

  // ----------------------------------------------------------------------
  // measurement clock domain
  // ----------------------------------------------------------------------

  // latching needs select idle, sync active, serial clock idle high
  assign lat_cond = mtsp_idle_sync(mc.sel_n, mc.syn, mc.clk, 1'b1);
  // remote reset: select idle, sync active, serial clock held low
  assign rrr_cond = mtsp_idle_sync(mc.sel_n, mc.syn, mc.clk, 1'b0);

  always_comb begin
    next_mc            = mc;
    next_mc.sel_n_meta = PORT_SELECT_N_I;
    next_mc.sel_n      = mc.sel_n_meta;
    next_mc.syn_meta   = SYNC_DIRECTION_I;
    next_mc.syn        = mc.syn_meta;
    next_mc.clk_meta   = SERIAL_CLOCK_SIGNAL_I;
    next_mc.clk        = mc.clk_meta;
    // written bits are static levels, each bit synchronised alone
    next_mc.cfg_meta   = cfg_w;
    next_mc.cfg        = mc.cfg_meta;
    next_mc.mode_meta  = mode_w;
    next_mc.mode       = mc.mode_meta;

    unique case (mc.lat)
      mtsp_pkg::MTSP_LAT_IDLE: begin
        next_mc.lat_cnt = 2'h0;
        if (lat_cond) begin
          next_mc.lat     = mtsp_pkg::MTSP_LAT_COUNT;
          next_mc.lat_cnt = 2'h1;
        end
      end
      mtsp_pkg::MTSP_LAT_COUNT: begin
        if (!lat_cond) begin
          next_mc.lat = mtsp_pkg::MTSP_LAT_IDLE;
        end else if (mc.lat_cnt == 2'(`MTSP_LATCH_PERIODS)) begin
          // pulse outlasted two measurement clocks: take a snapshot
          next_mc.hold = RECORD_I;
          next_mc.lat  = mtsp_pkg::MTSP_LAT_DONE;
        end else begin
          next_mc.lat_cnt = mc.lat_cnt + 2'h1;
        end
      end
      mtsp_pkg::MTSP_LAT_DONE: begin
        // one snapshot per pulse; a reread shifts the same data again
        if (!lat_cond) begin
          next_mc.lat = mtsp_pkg::MTSP_LAT_IDLE;
        end
      end
      default: begin
        next_mc.lat = mtsp_pkg::MTSP_LAT_IDLE;
      end
    endcase

    if (!rrr_cond) begin
      next_mc.rrr_cnt = 2'h0;
      next_mc.remote_reset_request     = 1'b0;
    end else if (mc.rrr_cnt == 2'(`MTSP_STEP_CLKS)) begin
      next_mc.remote_reset_request = 1'b1;
    end else begin
      next_mc.rrr_cnt = mc.rrr_cnt + 2'h1;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mc            <= '0;
      mc.sel_n_meta <= 1'b1;
      mc.sel_n      <= 1'b1;
      mc.syn_meta   <= 1'b1;
      mc.syn        <= 1'b1;
      mc.clk_meta   <= 1'b1;
      mc.clk        <= 1'b1;
      mc.lat        <= mtsp_pkg::MTSP_LAT_IDLE;
      mc.cfg_meta   <= `MTSP_CFG_RESET;
      mc.cfg        <= `MTSP_CFG_RESET;
      mc.mode_meta  <= `MTSP_MODE_RESET;
      mc.mode       <= `MTSP_MODE_RESET;
    end else begin
      mc <= next_mc;
    end
  end

  assign CONFIG_O               = mc.cfg;
  assign MODE_O                 = mc.mode;
  assign REMOTE_RESET_REQUEST_O = mc.remote_reset_request;

  // ----------------------------------------------------------------------
  // read path, link domain
  // ----------------------------------------------------------------------

  // the snapshot only moves while select is idle, so it is quasi-static
  // while this side shifts; no per-word handshake is needed
  assign rd_mode = ~PORT_SELECT_N_I & SYNC_DIRECTION_I;
  // any active sync level clears the bit counter, with or without clocks
  assign rd_rst  = RST_I | ~SYNC_DIRECTION_I;
  assign cnt_inc = rd.cnt + 8'h1;

  assign first_word = mtsp_serialize(mc.hold[mtsp_slot(3'h0, swap_w)], lsb_first);
  assign next_word  = mtsp_serialize(mc.hold[mtsp_slot(cnt_inc[7:5], swap_w)], lsb_first);

  always_comb begin
    next_rd      = rd;
    next_rd.last = 1'b0;
    if (rd_mode) begin
      next_rd.cnt    = cnt_inc;
      next_rd.last   = (rd.cnt == 8'(`MTSP_CNT_LAST - 8'h1));
      next_rd.loaded = 1'b1;
      if (cnt_inc[4:0] == 5'h0) begin
        next_rd.tx = next_word;
      end else if (rd.loaded) begin
        next_rd.tx = {rd.tx[30:0], 1'b0};
      end else begin
        next_rd.tx = {first_word[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge SERIAL_CLOCK_SIGNAL_I or posedge rd_rst) begin
    if (rd_rst) begin
      rd <= '0;
    end else begin
      rd <= next_rd;
    end
  end

  // ----------------------------------------------------------------------
  // data pin
  // ----------------------------------------------------------------------

  // first bit must stand before the first clock, so it comes straight
  // from the snapshot until the latch has taken over
  assign SERIAL_DATA_SIGNAL_O    = rd.loaded ? rd.tx[31] : first_word[31];
  // driver follows the pins with no delay; select release aborts at once
  assign SERIAL_DATA_SIGNAL_OE_O = rd_mode;

endmodule

//--- logic/mtsp_regs.svh
`ifndef MTSP_REGS_SVH
`define MTSP_REGS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define MTSP_MCLK_PERIOD_PS 40000
`define MTSP_STEP_NS        30
`define MTSP_STEP_CLKS      ((`MTSP_STEP_NS * 1000 + `MTSP_MCLK_PERIOD_PS - 1) / `MTSP_MCLK_PERIOD_PS)
`define MTSP_LATCH_PERIODS  2

// ----------------------------------------------------------------------
// record stream layout
// ----------------------------------------------------------------------
`define MTSP_RECORDS        8
`define MTSP_WORD_BITS      32
`define MTSP_PARITY_LSB     28
`define MTSP_CNT_LAST       8'hFF

// ----------------------------------------------------------------------
// write command layout and latch addresses
// ----------------------------------------------------------------------
`define MTSP_CMD_LAST       3'h7
`define MTSP_CFG_BITS       56
`define MTSP_MODE_BITS      7
`define MTSP_MODE_BASE      6'h38
`define MTSP_SWAP_ADDR      6'h3F
`define MTSP_ORDER_ADDR     6'h00

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MTSP_CFG_RESET      56'h0
`define MTSP_MODE_RESET     7'h0

`endif

//--- logic/mtsp_pkg.sv
package mtsp_pkg;

  typedef logic [31:0]       mtsp_word_t;
  typedef logic [7:0][31:0]  mtsp_records_t;
  typedef logic [55:0]       mtsp_cfg_t;
  typedef logic [6:0]        mtsp_mode_t;

  typedef enum logic [1:0] {
    MTSP_LAT_IDLE  = 2'b00,
    MTSP_LAT_COUNT = 2'b01,
    MTSP_LAT_DONE  = 2'b11
  } mtsp_lat_t;

  // measurement clock domain
  typedef struct packed {
    logic          sel_n_meta;
    logic          sel_n;
    logic          syn_meta;
    logic          syn;
    logic          clk_meta;
    logic          clk;
    mtsp_lat_t     lat;
    logic [1:0]    lat_cnt;
    mtsp_records_t hold;
    mtsp_cfg_t     cfg_meta;
    mtsp_cfg_t     cfg;
    mtsp_mode_t    mode_meta;
    mtsp_mode_t    mode;
    logic [1:0]    rrr_cnt;
    logic          remote_reset_request;
  } mtsp_mclk_t;

  // read side of the link, trailing serial clock edge
  typedef struct packed {
    logic [7:0]  cnt;
    mtsp_word_t  tx;
    logic        loaded;
    logic        last;
  } mtsp_rd_t;

  // write side of the link, leading serial clock edge
  typedef struct packed {
    logic [6:0]  sh;
    logic [2:0]  bcnt;
  } mtsp_wsh_t;

  typedef struct packed {
    mtsp_cfg_t   cfg;
    mtsp_mode_t  mode;
    logic        swap;
  } mtsp_wlat_t;

endpackage

//--- logic/mtsp_write.sv
`timescale 1ns/1ps
`include "mtsp_regs.svh"

module mtsp_write (
  // link clock and power-on reset
  input  wire logic             sclk_i,
  input  wire logic             por_i,
  // port pins
  input  wire logic             sel_n_i,
  input  wire logic             syn_i,
  input  wire logic             sdi_i,
  // read side
  input  wire logic             rd_last_i,
  // written latches
  output mtsp_pkg::mtsp_cfg_t   cfg_o,
  output mtsp_pkg::mtsp_mode_t  mode_o,
  output logic                  swap_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mtsp_pkg::mtsp_wsh_t  wsh;
  mtsp_pkg::mtsp_wsh_t  next_wsh;
  mtsp_pkg::mtsp_wlat_t wlat;
  mtsp_pkg::mtsp_wlat_t next_wlat;
  logic                 wr_mode;
  logic                 sh_rst;
  logic                 exec;
  logic [5:0]           addr;

  // leaving write mode drops a half-shifted command, latches stay intact
  assign wr_mode = ~sel_n_i & ~syn_i;
  assign sh_rst  = por_i | ~wr_mode;
  assign exec    = wr_mode & (wsh.bcnt == `MTSP_CMD_LAST);
  assign addr    = wsh.sh[5:0];

  // ----------------------------------------------------------------------
  // command shifter, leading edge
  // ----------------------------------------------------------------------
  always_comb begin
    next_wsh = wsh;
    if (wsh.bcnt == `MTSP_CMD_LAST) begin
      next_wsh.bcnt = 3'h0;
    end else begin
      next_wsh.sh   = {wsh.sh[5:0], sdi_i};
      next_wsh.bcnt = wsh.bcnt + 3'h1;
    end
  end

  always_ff @(negedge sclk_i or posedge sh_rst) begin
    if (sh_rst) begin
      wsh <= '0;
    end else begin
      wsh <= next_wsh;
    end
  end

  // ----------------------------------------------------------------------
  // latches, struck by the execute clock; config and mode cleared by power-on only
  // ----------------------------------------------------------------------
  always_comb begin
    next_wlat = wlat;
    if (exec) begin
      // any executed command other than the reorder request drops it
      next_wlat.swap = 1'b0;
      if (addr < `MTSP_MODE_BASE) begin
        next_wlat.cfg[addr] = wsh.sh[6];
      end else if (addr == `MTSP_SWAP_ADDR) begin
        next_wlat.swap = wsh.sh[6];
      end else begin
        next_wlat.mode[addr[2:0]] = wsh.sh[6];
      end
    end else if (~sel_n_i & syn_i & rd_last_i) begin
      next_wlat.swap = 1'b0;
    end
  end

  always_ff @(negedge sclk_i or posedge por_i) begin
    if (por_i) begin
      wlat.cfg  <= `MTSP_CFG_RESET;
      wlat.mode <= `MTSP_MODE_RESET;
      wlat.swap <= 1'b0;
    end else begin
      wlat <= next_wlat;
    end
  end

  assign cfg_o  = wlat.cfg;
  assign mode_o = wlat.mode;
  assign swap_o = wlat.swap;

endmodule

//--- sim/mtsp_serial_port_asserts.sv
`timescale 1ns/1ps

module mtsp_serial_port_asserts (
  // clock and reset
  input wire logic                  MCLK_I,
  input wire logic                  RST_I,
  // link pins
  input wire logic                  SERIAL_CLOCK_SIGNAL_I,
  input wire logic                  PORT_SELECT_N_I,
  input wire logic                  SYNC_DIRECTION_I,
  input wire logic                  SERIAL_DATA_SIGNAL_OE_O,
  // written bits and internal reset
  input wire mtsp_pkg::mtsp_cfg_t   CONFIG_O,
  input wire mtsp_pkg::mtsp_mode_t  MODE_O,
  input wire logic                  REMOTE_RESET_REQUEST_O
);
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  oe_read_a: assert property (SERIAL_DATA_SIGNAL_OE_O == (!PORT_SELECT_N_I && SYNC_DIRECTION_I))
    else $error("data driver enable does not follow select and sync");
  oe_idle_a: assert property (PORT_SELECT_N_I |-> !SERIAL_DATA_SIGNAL_OE_O)
    else $error("data driver on while deselected");
  por_clear_a: assert property ($fell(RST_I) |-> CONFIG_O == '0 && MODE_O == '0 && !REMOTE_RESET_REQUEST_O)
    else $error("power-on reset left bits set");
  rrr_keep_a: assert property (REMOTE_RESET_REQUEST_O |-> $stable(CONFIG_O) && $stable(MODE_O))
    else $error("remote reset changed stored bits");
  // pins pass two synchroniser stages and the count, so the cause is seen three cycles back
  rrr_cause_a: assert property ($rose(REMOTE_RESET_REQUEST_O) |->
      $past(PORT_SELECT_N_I, 3) && !$past(SYNC_DIRECTION_I, 3) && !$past(SERIAL_CLOCK_SIGNAL_I, 3))
    else $error("remote reset without its pin pattern");
  rrr_timely_a: assert property ((PORT_SELECT_N_I && !SYNC_DIRECTION_I && !SERIAL_CLOCK_SIGNAL_I) [*8]
      |-> REMOTE_RESET_REQUEST_O)
    else $error("remote reset not raised in time");
  rrr_release_a: assert property ((!(PORT_SELECT_N_I && !SYNC_DIRECTION_I && !SERIAL_CLOCK_SIGNAL_I)) [*8]
      |-> !REMOTE_RESET_REQUEST_O)
    else $error("remote reset not released in time");
  wr_quiet_a: assert property (SYNC_DIRECTION_I [*8] |-> $stable(CONFIG_O) && $stable(MODE_O))
    else $error("stored bits changed outside write mode");
endmodule

bind mtsp_serial_port mtsp_serial_port_asserts u_chk (
  .MCLK_I                  (MCLK_I),
  .RST_I                   (RST_I),
  .SERIAL_CLOCK_SIGNAL_I   (SERIAL_CLOCK_SIGNAL_I),
  .PORT_SELECT_N_I         (PORT_SELECT_N_I),
  .SYNC_DIRECTION_I        (SYNC_DIRECTION_I),
  .SERIAL_DATA_SIGNAL_OE_O (SERIAL_DATA_SIGNAL_OE_O),
  .CONFIG_O                (CONFIG_O),
  .MODE_O                  (MODE_O),
  .REMOTE_RESET_REQUEST_O  (REMOTE_RESET_REQUEST_O)
);

//--- sim/mtsp_host.sv
`timescale 1ns/1ps

module mtsp_host (
  // resolved data pin
  input  wire logic  sda_i,
  // driven pins
  output logic       sclk_o,
  output logic       sel_n_o,
  output logic       syn_o,
  output logic       sda_o,
  output logic       sda_oe_o
);
  // ----------------------------------------------------------------------
  // pin steps, 40 ns each so every interval exceeds 30 ns
  // ----------------------------------------------------------------------
  initial begin
    {sel_n_o, syn_o, sclk_o, sda_o} = 4'hF;
    sda_oe_o = 1'b0;
  end

  task automatic pins(input logic s, input logic y, input logic c);
    sel_n_o = s;
    syn_o = y;
    sclk_o = c;
    #40;
  endtask

  // latch pulse well over two clocks, then select, short sync pulse, clocks
  task automatic read(input int n, input bit relatch, output logic [255:0] q);
    q = '1;
    #13;
    if (relatch) begin
      pins(1'b1, 1'b0, 1'b1);
      #800;
    end
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b0, 1'b1, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    pins(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      q[i] = sda_i;
      sclk_o = 1'b0;
      #40;
      sclk_o = 1'b1;
      #40;
    end
    pins(1'b1, 1'b1, 1'b1);
  endtask

  // n below eight cuts the command short by releasing select
  task automatic write(input logic [7:0] cmd, input int n);
    #13;
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    sda_oe_o = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      sda_o = cmd[i];
      #40;
      sclk_o = 1'b0;
      #40;
      sclk_o = 1'b1;
    end
    #40;
    sda_oe_o = 1'b0;
    pins(1'b1, 1'b1, 1'b1);
  endtask

  task automatic rreset();
    #13;
    pins(1'b1, 1'b1, 1'b0);
    pins(1'b1, 1'b0, 1'b0);
    #360;
    pins(1'b1, 1'b1, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
  endtask
endmodule

//--- sim/mtsp_serial_port_bench.sv
`timescale 1ns/1ps

module mtsp_serial_port_bench;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic                    mclk = 1'b0;
  logic                    rst = 1'b1;
  logic                    sclk, sel_n, syn, d_dev, oe_dev, h_d, h_oe, sda, rr_seen = 1'b0;
  mtsp_pkg::mtsp_records_t rec = '0;
  mtsp_pkg::mtsp_records_t snap = '0;
  mtsp_pkg::mtsp_cfg_t     cfg, cfgm = '0;
  mtsp_pkg::mtsp_mode_t    mode, modem = '0;
  logic                    remote_reset_request;
  logic [31:0]             seed = 32'h8;
  logic [5:0]              a;
  logic                    v;
  int                      bad_count = 0;
  int                      n_checks = 0;

  always #20 mclk = ~mclk;
  // pull-up wins when nobody drives
  assign sda = oe_dev ? d_dev : (h_oe ? h_d : 1'b1);
  always @(posedge remote_reset_request) rr_seen = 1'b1;

  mtsp_serial_port dut (
    .MCLK_I(mclk), .RST_I(rst), .SERIAL_CLOCK_SIGNAL_I(sclk), .PORT_SELECT_N_I(sel_n),
    .SYNC_DIRECTION_I(syn), .SERIAL_DATA_SIGNAL_I(sda), .SERIAL_DATA_SIGNAL_O(d_dev),
    .SERIAL_DATA_SIGNAL_OE_O(oe_dev), .RECORD_I(rec), .CONFIG_O(cfg), .MODE_O(mode),
    .REMOTE_RESET_REQUEST_O(remote_reset_request)
  );
  mtsp_host host (.sda_i(sda), .sclk_o(sclk), .sel_n_o(sel_n), .syn_o(syn), .sda_o(h_d), .sda_oe_o(h_oe));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_bit(input mtsp_pkg::mtsp_records_t r, input bit sw, input bit lsbf, input int k);
    mtsp_pkg::mtsp_word_t w;
    logic [3:0]           p;
    w = r[((k / 32) + (sw ? 4 : 0)) % 8];
    p = '0;
    for (int i = 0; i < 7; i++) p ^= w[i*4 +: 4];
    w[31:28] = p;
    return w[(k % 32) / 8 * 8 + (lsbf ? k % 8 : 7 - k % 8)];
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic new_rec();
    @(negedge mclk);
    for (int i = 0; i < 8; i++) rec[i] = xs();
  endtask

  task automatic rd(input int n, input bit rl, input bit sw);
    logic [255:0] q;
    if (rl) snap = rec;
    host.read(n, rl, q);
    for (int k = 0; k < n; k++) chk("read bit", 64'(q[k]), 64'(exp_bit(snap, sw, cfgm[0], k)));
  endtask

  task automatic wr(input logic [5:0] ad, input logic val);
    host.write({val, ad, 1'b1}, 8);
    if (ad < 56) cfgm[ad] = val;
    else if (ad < 63) modem[ad - 56] = val;
    repeat (5) @(negedge mclk);
    chk("config", 64'(cfg), 64'(cfgm));
    chk("mode", 64'(mode), 64'(modem));
  endtask

  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("config after reset", 64'(cfg), 64'h0);
    new_rec();
    rd(256, 1'b1, 1'b0);
    new_rec();
    rd(32, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      a = 6'(xs() % 56);
      v = xs() & 1;
      wr(a, v);
    end
    wr(6'h00, 1'b1);
    for (int n = 0; n < 7; n++) wr(6'(56 + n), n[0]);
    host.write(8'hFF, 8);
    new_rec();
    rd(256, 1'b1, 1'b1);
    rd(32, 1'b1, 1'b0);
    host.write(8'hFF, 8);
    wr(6'h01, cfgm[1]);
    rd(32, 1'b1, 1'b0);
    host.write({~cfgm[5], 6'h05, 1'b1}, 4);
    repeat (5) @(negedge mclk);
    chk("config after cut command", 64'(cfg), 64'(cfgm));
    chk("driver after cut command", 64'(oe_dev), 64'h0);
    new_rec();
    rd(10, 1'b1, 1'b0);
    chk("driver after abort", 64'(oe_dev), 64'h0);
    host.rreset();
    repeat (8) @(negedge mclk);
    chk("remote reset seen", 64'(rr_seen), 64'h1);
    chk("remote reset released", 64'(remote_reset_request), 64'h0);
    chk("config after remote reset", 64'(cfg), 64'(cfgm));
    chk("mode after remote reset", 64'(mode), 64'(modem));
    @(negedge mclk) rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk("config after power-on", 64'(cfg), 64'h0);
    chk("mode after power-on", 64'(mode), 64'h0);
    end_sim();
  end

  // the whole sequence needs under 100 us, so 200 us means a hang
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule
